// File: pmic_serial_pkg.sv
// Constants for the power manager serial status and interrupt block
package pmic_serial_pkg;
    // ==========================================================
    // Bus addressing
    localparam logic [5:0] DEV_ADDR_HI = 6'h24;       // Fixed upper address bits 100100
    localparam logic [7:0] UNMAPPED_DATA = 8'hff;     // Answer for unknown registers
    // ==========================================================
    // Register offsets
    localparam logic [7:0] CHARGE_STATE_FLAGS_ADDR = 8'h01;
    localparam logic [7:0] REGULATOR_STATE_FLAGS_ADDR = 8'h02;
    localparam logic [7:0] CHARGE_INTERRUPT_BLOCK_ADDR = 8'h03;
    localparam logic [7:0] REGULATOR_INTERRUPT_BLOCK_ADDR = 8'h04;
    // ==========================================================
    // Reset values
    localparam logic [7:0] STATE_FLAGS_RST = 8'h00;
    localparam logic [7:0] INTERRUPT_BLOCK_RST = 8'hff;
    // ==========================================================
    // Field layouts
    localparam logic [7:0] CHARGE_EDGE_BITS = 8'h21;  // Bits 5 and 0 set on rising edge
    localparam logic [7:0] CHARGE_WCLR_BITS = 8'h1e;  // Bits 4..1 cleared by a write
    localparam logic [7:0] REG_EDGE_BITS = 8'he0;     // Bits 7..5 set on rising edge
    localparam int LDO2_EN_BIT = 7;                   // Enable of second LDO
    localparam int LDO1_EN_BIT = 3;                   // Enable of first LDO
    localparam int CORE_LP_BIT = 7;                   // Core low-power flag enable
    // ==========================================================
    // Timing
    localparam int SCL_MAX_KHZ = 400;                 // Fastest serial clock allowed
    localparam int CLK_KHZ = 100000;                  // Core clock rate
    localparam int MIN_OVERSAMPLE = 8;                // Core cycles needed per serial period
    localparam int SCL_HALF_CYC = CLK_KHZ / (2 * SCL_MAX_KHZ); // Shortest serial phase
endpackage : pmic_serial_pkg

// File: pmic_serial_status_interrupt_regs.sv
// Serial slave with charge and regulator status, masks and interrupt output
`timescale 1ns/10ps
`default_nettype none
module pmic_serial_status_interrupt_regs
    import pmic_serial_pkg::*;
#(
    parameter int CORE_KHZ = CLK_KHZ                  // Core clock rate in kHz
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Serial bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic address_select_pin_i,
    // Charge conditions, bit order as the charge status register
    input wire logic [7:0] charge_cond_i,
    // Regulator conditions
    input wire logic power_button_request_i,
    input wire logic battery_lid_detect_n_i,
    input wire logic supply_undervoltage_i,
    input wire logic [3:0] regulation_fault_i,
    input wire logic low_power_i,
    // Regulator control registers on this clock
    input wire logic [7:0] ldo_control_reg_i,
    input wire logic [7:0] core_converter_ctrl_reg_i,
    // Charger control and interrupt pin
    output logic charger_reset_o,
    output logic int_n_o,
    output logic int_n_oe_o
);
    // ==========================================================
    // Elaboration check
    // Refuse a core clock too slow to oversample the fastest serial clock
    if (CORE_KHZ < MIN_OVERSAMPLE * SCL_MAX_KHZ) begin : g_clk_check
        $error("Core clock too slow to sample the serial bus");
    end

    // ==========================================================
    // Types and declarations
    typedef enum logic [6:0] {
        S_IDLE = 7'h01,  // Bus free or not addressed
        S_ADDR = 7'h02,  // Receiving device address
        S_REG = 7'h04,   // Receiving register address
        S_WDATA = 7'h08, // Receiving write data
        S_ACK = 7'h10,   // Device drives acknowledge, or waits out the master's
        S_TX = 7'h20,    // Device shifts data out
        S_MACK = 7'h40   // Master acknowledge slot
    } link_state_t;

    localparam int NSYNC = 19;                        // Synchronised pin count
    logic [NSYNC-1:0] pins_a;                         // Raw asynchronous pins
    logic [NSYNC-1:0] meta_q;                         // First synchroniser stage
    logic [NSYNC-1:0] sync_q;                         // Second synchroniser stage
    logic scl_prev_q, scl_prev_d;                     // Clock level last cycle
    logic sda_prev_q, sda_prev_d;                     // Data level last cycle
    logic [7:0] chg_prev_q, chg_prev_d;               // Charge conditions last cycle
    logic [7:0] regc_prev_q, regc_prev_d;             // Regulator conditions last cycle
    link_state_t state_q, state_d;                    // Link state
    link_state_t after_q, after_d;                    // State after acknowledge
    logic [3:0] cnt_q, cnt_d;                         // Bit counter
    logic [7:0] sh_q, sh_d;                           // Receive shifter
    logic [7:0] tx_q, tx_d;                           // Transmit shifter
    logic [7:0] ptr_q, ptr_d;                         // Register pointer
    logic sda_oe_q, sda_oe_d;                         // Data line pulled low
    logic [7:0] chg_q, chg_d;                         // Charge state flags
    logic [7:0] reg_q, reg_d;                         // Regulator state flags
    logic [7:0] m1_q, m1_d;                           // Charge interrupt block
    logic [7:0] m2_q, m2_d;                           // Regulator interrupt block
    logic [7:0] ack1_q, ack1_d;                       // Charge acknowledge flags
    logic [7:0] ack2_q, ack2_d;                       // Regulator acknowledge flags
    logic int_oe_q, int_oe_d;                         // Interrupt pin pulled low
    logic crst_q, crst_d;                             // Charger reset pulse

    // ==========================================================
    // Read mux
    function automatic logic [7:0] read_byte(input logic [7:0] a, input logic [7:0] c,
                                             input logic [7:0] r, input logic [7:0] k1,
                                             input logic [7:0] k2);
        unique case (a)
            CHARGE_STATE_FLAGS_ADDR: read_byte = c;
            REGULATOR_STATE_FLAGS_ADDR: read_byte = r;
            CHARGE_INTERRUPT_BLOCK_ADDR: read_byte = k1;
            REGULATOR_INTERRUPT_BLOCK_ADDR: read_byte = k2;
            default: read_byte = UNMAPPED_DATA;
        endcase
    endfunction : read_byte

    // ==========================================================
    // Pin synchroniser
    assign pins_a = {low_power_i, regulation_fault_i, supply_undervoltage_i,
                     ~battery_lid_detect_n_i, power_button_request_i, charge_cond_i,
                     address_select_pin_i, sda_i, scl_i};

    // Two flops before any logic reads a pin
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= pins_a;
            sync_q <= meta_q;
        end
    end

    // ==========================================================
    // Next-state logic
    always_comb begin
        logic scl, sda, rise, fall, start, stop;
        logic [7:0] chg_c, reg_c, wclr, rd1, rd2;
        scl = sync_q[0];
        sda = sync_q[1];
        chg_c = sync_q[10:3];
        // Lid bit is set while its pin is low
        reg_c = {sync_q[11], sync_q[12], sync_q[13], 1'b0,
                 sync_q[17] & ldo_control_reg_i[LDO2_EN_BIT],
                 sync_q[16] & ldo_control_reg_i[LDO1_EN_BIT],
                 sync_q[15],
                 sync_q[14] | (sync_q[18] & core_converter_ctrl_reg_i[CORE_LP_BIT])};
        rise = scl & ~scl_prev_q;
        fall = ~scl & scl_prev_q;
        // Data edges while clock high mark start and stop
        start = scl & scl_prev_q & sda_prev_q & ~sda;
        stop = scl & scl_prev_q & ~sda_prev_q & sda;
        wclr = 8'h00;
        rd1 = 8'h00;
        rd2 = 8'h00;
        scl_prev_d = scl;
        sda_prev_d = sda;
        chg_prev_d = chg_c;
        regc_prev_d = reg_c;
        state_d = state_q;
        after_d = after_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        tx_d = tx_q;
        ptr_d = ptr_q;
        sda_oe_d = sda_oe_q;
        m1_d = m1_q;
        m2_d = m2_q;
        crst_d = 1'b0;

        // Serial link
        if (stop) begin
            state_d = S_IDLE;
            sda_oe_d = 1'b0;
        end else if (start) begin
            state_d = S_ADDR;
            cnt_d = 4'h0;
            sda_oe_d = 1'b0;
        end else begin
            unique case (state_q)
                S_IDLE: begin
                    sda_oe_d = 1'b0;                   // Bus left alone
                end
                S_ADDR, S_REG, S_WDATA: begin
                    // Bits taken on clock rise
                    if (rise && cnt_q < 4'h8) begin
                        sh_d = {sh_q[6:0], sda};
                        cnt_d = cnt_q + 4'h1;
                    end else if (fall && cnt_q == 4'h8) begin
                        // Eighth bit done: decide and acknowledge
                        sda_oe_d = 1'b1;
                        state_d = S_ACK;
                        if (state_q == S_ADDR) begin
                            if (sh_q[7:1] == {DEV_ADDR_HI, sync_q[2]}) begin
                                after_d = sh_q[0] ? S_TX : S_REG;
                            end else begin
                                sda_oe_d = 1'b0;       // Not ours
                                state_d = S_IDLE;
                            end
                        end else if (state_q == S_REG) begin
                            ptr_d = sh_q;
                            after_d = S_WDATA;
                        end else begin
                            after_d = S_WDATA;
                            // Register writes
                            unique case (ptr_q)
                                CHARGE_STATE_FLAGS_ADDR: begin
                                    wclr = sh_q & CHARGE_WCLR_BITS;
                                    crst_d = |wclr;
                                end
                                CHARGE_INTERRUPT_BLOCK_ADDR: m1_d = sh_q;
                                REGULATOR_INTERRUPT_BLOCK_ADDR: m2_d = sh_q;
                                default: ;             // Read-only or unmapped
                            endcase
                        end
                    end
                end
                S_ACK: begin
                    // Ninth clock ends: release or present first bit
                    if (fall) begin
                        cnt_d = 4'h0;
                        state_d = after_q;
                        sda_oe_d = 1'b0;
                        if (after_q == S_TX) begin
                            tx_d = read_byte(ptr_q, chg_q, reg_q, m1_q, m2_q);
                            sda_oe_d = ~tx_d[7];
                            // Latched set bits become acknowledged
                            if (ptr_q == CHARGE_STATE_FLAGS_ADDR) begin
                                rd1 = chg_q;
                            end
                            if (ptr_q == REGULATOR_STATE_FLAGS_ADDR) begin
                                rd2 = reg_q;
                            end
                        end
                    end
                end
                S_TX: begin
                    // Next bit on each falling edge
                    if (fall) begin
                        if (cnt_q == 4'h7) begin
                            sda_oe_d = 1'b0;
                            state_d = S_MACK;
                        end else begin
                            tx_d = {tx_q[6:0], 1'b1};
                            sda_oe_d = ~tx_q[6];
                            cnt_d = cnt_q + 4'h1;
                        end
                    end
                end
                S_MACK: begin
                    // Master acknowledge sampled on rise
                    if (rise) begin
                        if (sda) begin
                            state_d = S_IDLE;
                        end else begin
                            state_d = S_ACK;
                            after_d = S_TX;
                        end
                    end
                end
                default: begin
                    state_d = S_IDLE;
                    sda_oe_d = 1'b0;
                end
            endcase
        end

        // Charge flags: edge bits held until low and acknowledged
        chg_d = (chg_q & CHARGE_EDGE_BITS & ~(~chg_c & ack1_q))
              | (chg_c & ~chg_prev_q & CHARGE_EDGE_BITS)
              | (chg_c & ~CHARGE_EDGE_BITS & ~wclr);
        // Regulator flags
        reg_d = (reg_q & REG_EDGE_BITS & ~(~reg_c & ack2_q))
              | (reg_c & ~regc_prev_q & REG_EDGE_BITS)
              | (reg_c & ~REG_EDGE_BITS);
        // Acknowledge flags follow their status bit
        ack1_d = (ack1_q | rd1) & chg_d;
        ack2_d = (ack2_q | rd2) & reg_d;
        // Interrupt pin pulled low while anything pending
        int_oe_d = |(chg_q & ~m1_q & ~ack1_q)
                 | |(reg_q & ~m2_q & ~ack2_q);
    end

    // ==========================================================
    // State registers
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            chg_prev_q <= 8'h00;
            regc_prev_q <= 8'h00;
            state_q <= S_IDLE;
            after_q <= S_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            ptr_q <= 8'h00;
            sda_oe_q <= 1'b0;
            chg_q <= STATE_FLAGS_RST;
            reg_q <= STATE_FLAGS_RST;
            m1_q <= INTERRUPT_BLOCK_RST;
            m2_q <= INTERRUPT_BLOCK_RST;
            ack1_q <= 8'h00;
            ack2_q <= 8'h00;
            int_oe_q <= 1'b0;
            crst_q <= 1'b0;
        end else begin
            scl_prev_q <= scl_prev_d;
            sda_prev_q <= sda_prev_d;
            chg_prev_q <= chg_prev_d;
            regc_prev_q <= regc_prev_d;
            state_q <= state_d;
            after_q <= after_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            tx_q <= tx_d;
            ptr_q <= ptr_d;
            sda_oe_q <= sda_oe_d;
            chg_q <= chg_d;
            reg_q <= reg_d;
            m1_q <= m1_d;
            m2_q <= m2_d;
            ack1_q <= ack1_d;
            ack2_q <= ack2_d;
            int_oe_q <= int_oe_d;
            crst_q <= crst_d;
        end
    end

    // ==========================================================
    // Outputs
    assign sda_o = 1'b0;                               // Open drain: only pulls low
    assign sda_oe_o = sda_oe_q;
    assign int_n_o = 1'b0;                             // Open drain: only pulls low
    assign int_n_oe_o = int_oe_q;
    assign charger_reset_o = crst_q;

endmodule : pmic_serial_status_interrupt_regs
`default_nettype wire

// File: pmic_serial_sva.sv
// Checker for the serial status block pins
`timescale 1ns/10ps
`default_nettype none
module pmic_serial_sva (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Bus and pin outputs watched
    input wire logic scl_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic charger_reset_o,
    input wire logic int_n_o,
    input wire logic int_n_oe_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // ==========================================================
    // Idle counter
    logic [8:0] hi_cnt_q; // Cycles the serial clock stayed high
    logic [8:0] hi_cnt_d;
    // Count while high, saturate, restart when low
    always_comb begin
        hi_cnt_d = hi_cnt_q;
        if (!scl_i) begin
            hi_cnt_d = 9'h000;
        end else if (hi_cnt_q != 9'h1ff) begin
            hi_cnt_d = hi_cnt_q + 9'h001;
        end
    end
    // Register the counter
    always_ff @(posedge core_clk_i) begin
        hi_cnt_q <= rst_i ? 9'h000 : hi_cnt_d;
    end
    // ==========================================================
    // Properties
    property p_rst_quiet;
        $fell(rst_i) |-> !sda_oe_o && !int_n_oe_o && !charger_reset_o;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("pins active after reset");
    property p_sda_od;
        sda_o == 1'b0;
    endproperty
    a_sda_od: assert property (p_sda_od) else $error("data pin drives high");
    property p_int_od;
        int_n_o == 1'b0;
    endproperty
    a_int_od: assert property (p_int_od) else $error("interrupt pin drives high");
    property p_oe_scl_low;
        $changed(sda_oe_o) |-> !scl_i;
    endproperty
    a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved while clock high");
    property p_oe_hold;
        $rose(scl_i) |-> ($stable(sda_oe_o))[*8];
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("data unstable in clock high");
    property p_idle_free;
        hi_cnt_q >= 9'd300 |-> !sda_oe_o;
    endproperty
    a_idle_free: assert property (p_idle_free) else $error("data held on idle bus");
    property p_rst_pulse;
        charger_reset_o |=> !charger_reset_o;
    endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("charger reset too long");
    property p_rst_in_low;
        charger_reset_o |-> !scl_i ##1 !scl_i;
    endproperty
    a_rst_in_low: assert property (p_rst_in_low) else $error("charger reset off frame");
endmodule : pmic_serial_sva
`default_nettype wire

// File: serial_host_model.sv
// Two-wire bus master model that clocks the bus and pulls data low
`timescale 1ns/10ps
`default_nettype none
module serial_host_model #(
    parameter int QTR = 63 // Core cycles per quarter bit, bus stays under 400 kHz
) (
    // Clock
    input wire logic core_clk_i,
    // Bus
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_pull_o
);
    // Bus idles released
    initial begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end
    // Quarter bit wait
    task automatic qwait();
        repeat (QTR) @(posedge core_clk_i);
    endtask : qwait
    // One bit: data set while clock low, sampled mid high
    task automatic bit_io(input logic b, output logic r);
        sda_pull_o <= ~b;
        qwait();
        scl_o <= 1'b1;
        qwait();
        r = sda_i;
        qwait();
        scl_o <= 1'b0;
        qwait();
    endtask : bit_io
    // Eight bits then the acknowledge pulse
    task automatic byte_io(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                           output logic sack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(mack, sack);
    endtask : byte_io
    // Start or repeated start
    task automatic start();
        sda_pull_o <= 1'b0;
        qwait();
        scl_o <= 1'b1;
        qwait();
        sda_pull_o <= 1'b1;
        qwait();
        scl_o <= 1'b0;
        qwait();
    endtask : start
    // Stop
    task automatic stop();
        sda_pull_o <= 1'b1;
        qwait();
        scl_o <= 1'b1;
        qwait();
        sda_pull_o <= 1'b0;
        qwait();
    endtask : stop
    // Register write, ok when every byte acked
    task automatic wr(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] d,
                      output logic ok);
        logic [7:0] rx;
        logic a0, a1, a2;
        start();
        byte_io({dev, 1'b0}, 1'b1, rx, a0);
        byte_io(ra, 1'b1, rx, a1);
        byte_io(d, 1'b1, rx, a2);
        stop();
        ok = !(a0 | a1 | a2);
    endtask : wr
    // Register read with repeated start, last byte not acked
    task automatic rd(input logic [6:0] dev, input logic [7:0] ra, output logic [7:0] d,
                      output logic ok);
        logic [7:0] rx;
        logic a0, a1, a2, a3;
        start();
        byte_io({dev, 1'b0}, 1'b1, rx, a0);
        byte_io(ra, 1'b1, rx, a1);
        start();
        byte_io({dev, 1'b1}, 1'b1, rx, a2);
        byte_io(8'hff, 1'b1, d, a3);
        stop();
        ok = !(a0 | a1 | a2);
    endtask : rd
endmodule : serial_host_model
`default_nettype wire

// File: tb_top.sv
// Top bench for the serial status and interrupt block
`timescale 1ns/10ps
`default_nettype none
module tb_top import pmic_serial_pkg::*;;
    localparam logic [6:0] DEV = {DEV_ADDR_HI, 1'b1}; // Select pin held high
    // ==========================================================
    // Signals
    logic core_clk_i, rst_i, scl, pull, asel, pbr, lid_n, uv, lp, sda_od, sda_oe, chg_rst;
    logic int_n, int_oe;
    logic [7:0] chg_cond, ldo, core;
    logic [3:0] rf;
    wire logic sda;
    int err_total = 0, num_checks = 0, cyc = 0, pulses = 0;
    logic [31:0] seed = 32'd34434;
    // Open-drain data line with pull-up
    assign sda = (sda_oe ? sda_od : 1'b1) & ~pull;
    // Clock
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    pmic_serial_status_interrupt_regs DUT (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_od), .sda_oe_o(sda_oe),
        .address_select_pin_i(asel), .charge_cond_i(chg_cond), .power_button_request_i(pbr),
        .battery_lid_detect_n_i(lid_n), .supply_undervoltage_i(uv), .regulation_fault_i(rf),
        .low_power_i(lp), .ldo_control_reg_i(ldo), .core_converter_ctrl_reg_i(core),
        .charger_reset_o(chg_rst), .int_n_o(int_n), .int_n_oe_o(int_oe));
    serial_host_model host (.core_clk_i(core_clk_i), .sda_i(sda), .scl_o(scl),
        .sda_pull_o(pull));
    // ==========================================================
    // Helpers
    function automatic logic [7:0] rnd8();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd8
    // Expected value of a register right after reset
    function automatic logic [7:0] rst_val(input logic [7:0] a);
        case (a)
            CHARGE_INTERRUPT_BLOCK_ADDR, REGULATOR_INTERRUPT_BLOCK_ADDR: return INTERRUPT_BLOCK_RST;
            CHARGE_STATE_FLAGS_ADDR, REGULATOR_STATE_FLAGS_ADDR: return STATE_FLAGS_RST;
            default: return UNMAPPED_DATA;
        endcase
    endfunction : rst_val
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask : chk
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic ok;
        host.rd(DEV, a, d, ok);
        chk("read ack", 8'h01, {7'h00, ok});
        chk("read data", e, d);
    endtask : rd_chk
    // Let the pin synchronisers settle, then look at the interrupt pin
    task automatic int_chk(input logic e);
        repeat (8) @(posedge core_clk_i);
        chk("interrupt", {7'h00, e}, {7'h00, int_oe});
    endtask : int_chk
    task automatic summarize();
        $display("Checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize
    // Charger reset pulses and hang limit
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (chg_rst === 1'b1) pulses <= pulses + 1;
        if (cyc == 100000) begin
            err_total++;
            summarize();
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        logic [7:0] a, m;
        logic ok;
        int p0;
        rst_i = 1'b1;
        {asel, lid_n, pbr, uv, lp} = 5'b11000;
        {chg_cond, ldo, core, rf} = 28'h0000000;
        repeat (20) @(posedge core_clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        for (int i = 0; i < 3; i++) begin
            a = (i < 2) ? CHARGE_INTERRUPT_BLOCK_ADDR + i[7:0] : (8'h40 | rnd8());
            rd_chk(a, rst_val(a));
        end
        $display("reset values done");
        host.wr({DEV_ADDR_HI, 1'b0}, CHARGE_INTERRUPT_BLOCK_ADDR, 8'h00, ok);
        chk("foreign address ack", 8'h00, {7'h00, ok});
        m = rnd8() & 8'h7e;
        host.wr(DEV, CHARGE_INTERRUPT_BLOCK_ADDR, m, ok);
        rd_chk(CHARGE_INTERRUPT_BLOCK_ADDR, m);
        host.wr(DEV, REGULATOR_INTERRUPT_BLOCK_ADDR, 8'h00, ok);
        $display("addressing and masks done");
        int_chk(1'b0);
        chg_cond <= 8'h01;
        int_chk(1'b1);
        chg_cond <= 8'h00;
        int_chk(1'b1);
        rd_chk(CHARGE_STATE_FLAGS_ADDR, 8'h01);
        int_chk(1'b0);
        $display("charge interrupt done");
        chg_cond <= 8'h84;
        repeat (8) @(posedge core_clk_i);
        p0 = pulses;
        host.wr(DEV, CHARGE_STATE_FLAGS_ADDR, 8'hff, ok);
        chk("charger reset pulses", 8'h01, 8'(pulses - p0));
        rd_chk(CHARGE_STATE_FLAGS_ADDR, 8'h84);
        chg_cond <= 8'h00;
        int_chk(1'b0);
        $display("charge write done");
        rf <= 4'b0100;
        ldo <= rnd8() & 8'h77;
        int_chk(1'b0);
        ldo <= 8'h08;
        int_chk(1'b1);
        rd_chk(REGULATOR_STATE_FLAGS_ADDR, 8'h04);
        int_chk(1'b0);
        lp <= 1'b1;
        core <= 8'h80;
        int_chk(1'b1);
        $display("regulator interrupt done");
        summarize();
    end
endmodule : tb_top
bind pmic_serial_status_interrupt_regs pmic_serial_sva u_chk (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .charger_reset_o(charger_reset_o), .int_n_o(int_n_o), .int_n_oe_o(int_n_oe_o));
`default_nettype wire
